//--- shared/ecr_pkg.sv
package ecr_pkg;

    // Register map, byte addresses on the register port.
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL_STATE = 8'h00;
    localparam logic [7:0] OFF_TABLE_OFFSET = 8'h04;
    localparam logic [7:0] OFF_APP_RESET = 8'h08;

    // Interrupt control and state fields.
    localparam int unsigned TICK_CLR_BIT = 25;
    localparam int unsigned DEBUG_BIT = 23;
    localparam int unsigned IRQ_PEND_BIT = 22;
    localparam int unsigned PEND_NUM_LSB = 12;
    localparam int unsigned PEND_NUM_W = 6;
    localparam int unsigned RET_BASE_BIT = 11;
    localparam int unsigned ACT_NUM_LSB = 0;
    localparam int unsigned ACT_NUM_W = 9;

    // Vector table offset fields.
    localparam int unsigned TBL_LSB = 7;
    localparam int unsigned TBL_W = 25;
    localparam int unsigned TBL_REGION_BIT = 29;
    localparam logic [TBL_W-1:0] TBL_RESET = 25'h0000000;

    // Application interrupt and reset control fields.
    localparam int unsigned KEY_LSB = 16;
    localparam logic [15:0] KEY_WRITE = 16'h05fa;
    localparam logic [15:0] KEY_READ = 16'hfa05;
    localparam int unsigned ENDIAN_BIT = 15;
    localparam int unsigned SPLIT_LSB = 8;
    localparam int unsigned SPLIT_W = 3;
    localparam logic [SPLIT_W-1:0] SPLIT_RESET = 3'h0;
    localparam int unsigned SYS_RESET_BIT = 2;

    // Exception numbering.
    localparam int unsigned FIRST_EXC = 2;
    localparam int unsigned NMI_NUM = 2;
    localparam int unsigned FIRST_IRQ = 16;
    localparam logic [7:0] GROUP_BASE_MASK = 8'hfe;

    // Keeps only the group priority part of a priority value.
    function automatic logic [7:0] ecr_group(input logic [7:0] prio, input logic [2:0] split);
        logic [7:0] mask;
        mask = GROUP_BASE_MASK << split;
        return prio & mask;
    endfunction

endpackage

//--- logic/ecr_pend_arb.sv
`timescale 1ns/100ps
module ecr_pend_arb import ecr_pkg::*; #(
    parameter int unsigned NUM_EXC = 48
) (
    input wire logic [NUM_EXC-1:0] exc_pending,
    input wire logic [NUM_EXC-1:0] exc_enabled,
    input wire logic [NUM_EXC*8-1:0] exc_prio,
    input wire logic [7:0] base_priority_mask,
    input wire logic fault_mask_a,
    output logic best_valid,
    output logic [PEND_NUM_W-1:0] best_num,
    output logic [7:0] best_prio
);

    // A linear scan is cheap at this exception count; ties go to the lower number.
    always_comb begin
        logic [7:0] p;
        logic masked;
        p = 8'h00;
        masked = 1'b0;
        best_valid = 1'b0;
        best_num = '0;
        best_prio = 8'hff;
        for (int i = FIRST_EXC; i < NUM_EXC; i++) begin
            p = exc_prio[i*8 +: 8];
            masked = 1'b0;
            if (base_priority_mask != 8'h00 && p >= base_priority_mask) begin
                masked = 1'b1;
            end
            if (fault_mask_a && i != NMI_NUM) begin
                masked = 1'b1;
            end
            if (exc_pending[i] && exc_enabled[i] && !masked) begin
                if (!best_valid || p < best_prio) begin
                    best_valid = 1'b1;
                    best_num = PEND_NUM_W'(i);
                    best_prio = p;
                end
            end
        end
    end

endmodule // ecr_pend_arb

//--- logic/ecr_regs.sv
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
// Operation
// - Writing one to bit 25 clears tick timer pending; zero has no effect.
// - Bit 25 is write-only; its read value is unspecified.
// - Bit 23 reads zero whenever the processor is not halted in debug.
// - Bit 22 shows any interrupt pending, excluding non-maskable and fault exceptions.
// - Bits 17:12 give highest-priority pending enabled exception number, else zero.
// - Pending number honours base priority and fault masks, ignores global mask.
// - Bit 11 reads zero when preempted active exceptions remain, else one.
// - Bits 8:0 show active exception number, zero in thread mode.
// - Table offset register holds offset bits 31:7 in register bits 31:7.
// - Offset bit 29 selects code region (zero) or SRAM region (one).
// - Table offset bits 6:0 always read zero and ignore writes.
// - Reset control writes need key 0x5FA upper half; reads return 0xFA05.
// - Bit 15 reports the fixed data byte order, one for big-endian.
// - Bits 10:8 store the priority grouping setting.
// - Keyed write of one to bit 2 requests outer system reset; reads zero.
// - Grouping n makes priority bits 7:n+1 group, n:0 subpriority.
// - Only group priority decides preemption, never subpriority.
module ecr_regs import ecr_pkg::*; #(
    parameter int unsigned NUM_EXC = 48,
    parameter logic BIG_ENDIAN = 1'b0
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    input wire logic [NUM_EXC-1:0] exc_pending,
    input wire logic [NUM_EXC-1:0] exc_enabled,
    input wire logic [NUM_EXC-1:0] exc_active,
    input wire logic [NUM_EXC*8-1:0] exc_prio,
    input wire logic [ACT_NUM_W-1:0] active_exception_number,
    input wire logic [7:0] running_prio,
    input wire logic [7:0] base_priority_mask,
    input wire logic fault_mask_a,
    input wire logic debug_halted,
    input wire logic debug_state_bit,
    output logic tick_pend_clear,
    output logic [31:0] table_base_addr,
    output logic table_in_sram,
    output logic [SPLIT_W-1:0] priority_split,
    output logic preempt_allowed,
    output logic system_reset_request
);

    typedef struct packed {
        logic [TBL_W-1:0] tbl;
        logic [SPLIT_W-1:0] split;
        logic sys_rst;
        logic tick_clr;
        logic preempt;
        logic [31:0] rdata;
    } ecr_state_t;

    ecr_state_t state_ff;
    ecr_state_t nxt_state;

    logic best_valid;
    logic [PEND_NUM_W-1:0] best_num;
    logic [7:0] best_prio;
    logic irq_pending_flag;
    logic return_to_base_flag;
    logic key_ok;
    logic wr_ctrl;
    logic wr_tbl;
    logic wr_app;
    logic [31:0] ctrl_view;
    logic [31:0] tbl_view;
    logic [31:0] app_view;

    ecr_pend_arb #(
        .NUM_EXC(NUM_EXC)
    ) u_arb (
        .exc_pending(exc_pending),
        .exc_enabled(exc_enabled),
        .exc_prio(exc_prio),
        .base_priority_mask(base_priority_mask),
        .fault_mask_a(fault_mask_a),
        .best_valid(best_valid),
        .best_num(best_num),
        .best_prio(best_prio)
    );

    // Status that software reads, assembled from the live exception state.
    always_comb begin
        irq_pending_flag = |exc_pending[NUM_EXC-1:FIRST_IRQ];
        return_to_base_flag = (exc_active & (exc_active - 1'b1)) == '0;
        key_ok = bus_wdata[31:KEY_LSB] == KEY_WRITE;
        wr_ctrl = bus_wr && bus_addr == OFF_CTRL_STATE;
        wr_tbl = bus_wr && bus_addr == OFF_TABLE_OFFSET;
        wr_app = bus_wr && bus_addr == OFF_APP_RESET && key_ok;
    end

    always_comb begin
        ctrl_view = 32'h00000000;
        // The clear bit is returned as zero; software must not rely on it.
        ctrl_view[TICK_CLR_BIT] = 1'b0;
        ctrl_view[DEBUG_BIT] = debug_halted & debug_state_bit;
        ctrl_view[IRQ_PEND_BIT] = irq_pending_flag;
        if (best_valid) begin
            ctrl_view[PEND_NUM_LSB +: PEND_NUM_W] = best_num;
        end
        ctrl_view[RET_BASE_BIT] = return_to_base_flag;
        ctrl_view[ACT_NUM_LSB +: ACT_NUM_W] = active_exception_number;
    end

    always_comb begin
        tbl_view = 32'h00000000;
        tbl_view[TBL_LSB +: TBL_W] = state_ff.tbl;
    end

    always_comb begin
        app_view = 32'h00000000;
        app_view[31:KEY_LSB] = KEY_READ;
        app_view[ENDIAN_BIT] = BIG_ENDIAN;
        app_view[SPLIT_LSB +: SPLIT_W] = state_ff.split;
        // Request and debug bits stay zero on reads.
        app_view[SYS_RESET_BIT] = 1'b0;
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_state.tick_clr = wr_ctrl && bus_wdata[TICK_CLR_BIT];
        if (wr_tbl) begin
            // Low seven offset bits are not stored, so they can never read back as one.
            nxt_state.tbl = bus_wdata[TBL_LSB +: TBL_W];
        end
        if (wr_app) begin
            nxt_state.split = bus_wdata[SPLIT_LSB +: SPLIT_W];
            // Debug bits 1 and 0 are dropped here, which avoids any local reset side effect.
            if (bus_wdata[SYS_RESET_BIT]) begin
                nxt_state.sys_rst = 1'b1;
            end
        end
        // Preemption compares group parts only; thread mode can be preempted by anything.
        nxt_state.preempt = best_valid && (active_exception_number == '0 ||
            ecr_group(best_prio, state_ff.split) < ecr_group(running_prio, state_ff.split));
        nxt_state.rdata = 32'h00000000;
        if (bus_rd) begin
            unique case (bus_addr)
                OFF_CTRL_STATE: begin
                    nxt_state.rdata = ctrl_view;
                end
                OFF_TABLE_OFFSET: begin
                    nxt_state.rdata = tbl_view;
                end
                OFF_APP_RESET: begin
                    nxt_state.rdata = app_view;
                end
                default: begin
                    nxt_state.rdata = 32'h00000000;
                end
            endcase
        end
    end

    // The request is only dropped by reset so a slow reset controller cannot miss it.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_ff.tbl <= TBL_RESET;
            state_ff.split <= SPLIT_RESET;
            state_ff.sys_rst <= 1'b0;
            state_ff.tick_clr <= 1'b0;
            state_ff.preempt <= 1'b0;
            state_ff.rdata <= 32'h00000000;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_comb begin
        bus_rdata = state_ff.rdata;
        tick_pend_clear = state_ff.tick_clr;
        table_base_addr = tbl_view;
        table_in_sram = state_ff.tbl[TBL_REGION_BIT-TBL_LSB];
        priority_split = state_ff.split;
        preempt_allowed = state_ff.preempt;
        system_reset_request = state_ff.sys_rst;
    end

    default clocking ast_cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    AST_TICK_CLEAR: assert property (
        bus_wr && bus_addr == OFF_CTRL_STATE |=> tick_pend_clear == $past(bus_wdata[TICK_CLR_BIT]))
        else $error("tick clear pulse does not follow the written bit");

    AST_TICK_IDLE: assert property (
        !(bus_wr && bus_addr == OFF_CTRL_STATE) |=> !tick_pend_clear)
        else $error("tick clear pulse without a control write");

    AST_DEBUG_ZERO: assert property (
        bus_rd && bus_addr == OFF_CTRL_STATE && !debug_halted |=> bus_rdata[DEBUG_BIT] == 1'b0)
        else $error("debug bit reads one outside debug");

    AST_IRQ_PEND: assert property (
        bus_rd && bus_addr == OFF_CTRL_STATE |=> bus_rdata[IRQ_PEND_BIT] == $past(irq_pending_flag))
        else $error("interrupt pending flag mismatch");

    AST_PEND_NUM: assert property (
        bus_rd && bus_addr == OFF_CTRL_STATE && !best_valid |=> bus_rdata[PEND_NUM_LSB +: PEND_NUM_W] == '0)
        else $error("pending number not zero with nothing pending");

    AST_FAULT_MASK: assert property (
        fault_mask_a && best_valid |-> best_num == PEND_NUM_W'(NMI_NUM))
        else $error("fault mask let a non-NMI exception through");

    AST_RET_BASE: assert property (
        bus_rd && bus_addr == OFF_CTRL_STATE |=> bus_rdata[RET_BASE_BIT] == $past(return_to_base_flag))
        else $error("return to base flag mismatch");

    AST_ACT_NUM: assert property (
        bus_rd && bus_addr == OFF_CTRL_STATE
        |=> bus_rdata[ACT_NUM_LSB +: ACT_NUM_W] == $past(active_exception_number))
        else $error("active number mismatch");

    AST_TBL_LOW: assert property (
        bus_rd && bus_addr == OFF_TABLE_OFFSET |=> bus_rdata[TBL_LSB-1:0] == '0)
        else $error("table offset low bits not zero");

    AST_TBL_WRITE: assert property (
        wr_tbl |=> table_base_addr[31:TBL_LSB] == $past(bus_wdata[31:TBL_LSB]))
        else $error("table offset write not stored");

    AST_TBL_REGION: assert property (
        table_in_sram == table_base_addr[TBL_REGION_BIT])
        else $error("table region flag disagrees with the stored offset");

    // Read checks look one cycle after the strobe, the only cycle in which the read data stand.
    AST_TBL_READ: assert property (
        bus_rd && bus_addr == OFF_TABLE_OFFSET |=> bus_rdata == $past(table_base_addr))
        else $error("table offset readback differs from the stored value");

    AST_TBL_HOLD: assert property (
        !wr_tbl |=> $stable(table_base_addr))
        else $error("table offset changed without a write");

    AST_TICK_READ: assert property (
        bus_rd && bus_addr == OFF_CTRL_STATE |=> bus_rdata[TICK_CLR_BIT] == 1'b0)
        else $error("tick clear bit reads one");

    AST_CTRL_RSVD: assert property (
        bus_rd && bus_addr == OFF_CTRL_STATE
        |=> bus_rdata[31:TICK_CLR_BIT+1] == '0 && bus_rdata[TICK_CLR_BIT-1] == 1'b0 &&
            bus_rdata[IRQ_PEND_BIT-1:PEND_NUM_LSB+PEND_NUM_W] == '0 && bus_rdata[RET_BASE_BIT-1:ACT_NUM_W] == '0)
        else $error("reserved control bits not zero");

    AST_APP_RSVD: assert property (
        bus_rd && bus_addr == OFF_APP_RESET
        |=> bus_rdata[ENDIAN_BIT-1:SPLIT_LSB+SPLIT_W] == '0 && bus_rdata[SPLIT_LSB-1:SYS_RESET_BIT+1] == '0)
        else $error("reserved reset control bits not zero");

    AST_ENDIAN: assert property (
        bus_rd && bus_addr == OFF_APP_RESET |=> bus_rdata[ENDIAN_BIT] == BIG_ENDIAN)
        else $error("byte order bit wrong");

    AST_SPLIT_READ: assert property (
        bus_rd && bus_addr == OFF_APP_RESET |=> bus_rdata[SPLIT_LSB +: SPLIT_W] == $past(priority_split))
        else $error("grouping readback differs from the stored value");

    AST_SPLIT_HOLD: assert property (
        !wr_app |=> $stable(priority_split))
        else $error("grouping changed without a keyed write");

    AST_UNMAPPED_RD: assert property (
        bus_rd && bus_addr != OFF_CTRL_STATE && bus_addr != OFF_TABLE_OFFSET && bus_addr != OFF_APP_RESET
        |=> bus_rdata == '0)
        else $error("unmapped read returned nonzero data");

    AST_UNMAPPED_WR: assert property (
        bus_wr && bus_addr != OFF_CTRL_STATE && bus_addr != OFF_TABLE_OFFSET && bus_addr != OFF_APP_RESET
        |=> $stable(table_base_addr) && $stable(priority_split) && !tick_pend_clear)
        else $error("unmapped write changed state");

    AST_PEND_BEST: assert property (
        bus_rd && bus_addr == OFF_CTRL_STATE && best_valid
        |=> bus_rdata[PEND_NUM_LSB +: PEND_NUM_W] == $past(best_num))
        else $error("pending number differs from the winner");

    AST_PEND_RANGE: assert property (
        best_valid |-> best_num >= PEND_NUM_W'(FIRST_EXC))
        else $error("pending winner below the first exception number");

    AST_BASE_MASK: assert property (
        base_priority_mask != 8'h00 && best_valid |-> best_prio < base_priority_mask)
        else $error("base priority mask let a masked exception through");

    AST_IRQ_ZERO: assert property (
        bus_rd && bus_addr == OFF_CTRL_STATE && exc_pending[NUM_EXC-1:FIRST_IRQ] == '0
        |=> !bus_rdata[IRQ_PEND_BIT])
        else $error("interrupt pending flag set with no interrupt pending");

    AST_DEBUG_SHOW: assert property (
        bus_rd && bus_addr == OFF_CTRL_STATE && debug_halted |=> bus_rdata[DEBUG_BIT] == $past(debug_state_bit))
        else $error("debug bit does not follow debug state");

    // Preemption is registered, so these checks compare against the inputs of the cycle before.
    AST_PREEMPT_NONE: assert property (
        !best_valid |=> !preempt_allowed)
        else $error("preemption allowed with nothing pending");

    AST_PREEMPT_THREAD: assert property (
        best_valid && active_exception_number == '0 |=> preempt_allowed)
        else $error("thread mode not preempted by a pending exception");

    AST_PREEMPT_SPLIT: assert property (
        best_valid && active_exception_number != '0 && priority_split == '1 |=> !preempt_allowed)
        else $error("preemption allowed with no group priority bits");

    AST_RST_IDLE: assert property (
        !system_reset_request && !(wr_app && bus_wdata[SYS_RESET_BIT]) |=> !system_reset_request)
        else $error("reset request raised without a keyed write");

    AST_KEY_READ: assert property (
        bus_rd && bus_addr == OFF_APP_RESET |=> bus_rdata[31:KEY_LSB] == KEY_READ && bus_rdata[2:0] == 3'h0)
        else $error("key readback or write-only bits wrong");

    AST_KEY_REJECT: assert property (
        bus_wr && bus_addr == OFF_APP_RESET && !key_ok |=> $stable(priority_split) && $stable(system_reset_request))
        else $error("unkeyed write changed state");

    AST_SPLIT_WRITE: assert property (
        wr_app |=> priority_split == $past(bus_wdata[SPLIT_LSB +: SPLIT_W]))
        else $error("grouping field not stored on keyed write");

    AST_RST_SET: assert property (
        wr_app && bus_wdata[SYS_RESET_BIT] |=> system_reset_request [*3])
        else $error("reset request not raised and held");

    AST_RST_HOLD: assert property (
        system_reset_request |=> system_reset_request)
        else $error("reset request dropped without reset");

    COV_KEYED_WRITE: cover property (wr_app ##2 bus_rd && bus_addr == OFF_APP_RESET);
    COV_TICK_CLEAR: cover property (tick_pend_clear);
    COV_RESET_REQ: cover property (wr_app && bus_wdata[SYS_RESET_BIT]);
    COV_PEND_READ: cover property (best_valid && bus_rd && bus_addr == OFF_CTRL_STATE);
    COV_PREEMPT: cover property (preempt_allowed ##1 !preempt_allowed);

endmodule // ecr_regs

//--- verif/testbench.sv
`timescale 1ns/100ps
module testbench;
    import ecr_pkg::*;
    localparam int unsigned NE = 48;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [ADDR_W-1:0] bus_addr = 8'h00;
    logic [31:0] bus_wdata = 32'h0;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [31:0] bus_rdata;
    logic [NE-1:0] exc_pending = '0;
    logic [NE-1:0] exc_enabled = '0;
    logic [NE-1:0] exc_active = '0;
    logic [NE*8-1:0] exc_prio = '0;
    logic [ACT_NUM_W-1:0] active_exception_number = 9'h000;
    logic [7:0] running_prio = 8'h00;
    logic [7:0] base_priority_mask = 8'h00;
    logic fault_mask_a = 1'b0;
    logic debug_halted = 1'b0;
    logic debug_state_bit = 1'b0;
    logic tick_pend_clear;
    logic [31:0] table_base_addr;
    logic table_in_sram;
    logic [SPLIT_W-1:0] priority_split;
    logic preempt_allowed;
    logic system_reset_request;
    int mismatches = 0;
    int check_count = 0;

    always #20 ref_clk = ~ref_clk;

    ecr_regs #(.NUM_EXC(NE), .BIG_ENDIAN(1'b0)) u_ecr_regs (.ref_clk(ref_clk), .nrst(nrst), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .exc_pending(exc_pending),
        .exc_enabled(exc_enabled), .exc_active(exc_active), .exc_prio(exc_prio),
        .active_exception_number(active_exception_number), .running_prio(running_prio),
        .base_priority_mask(base_priority_mask), .fault_mask_a(fault_mask_a), .debug_halted(debug_halted),
        .debug_state_bit(debug_state_bit), .tick_pend_clear(tick_pend_clear), .table_base_addr(table_base_addr),
        .table_in_sram(table_in_sram), .priority_split(priority_split), .preempt_allowed(preempt_allowed),
        .system_reset_request(system_reset_request));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Effects of a write are visible one cycle after the strobe edge, so sample just after it.
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        #1;
        chk(nm, exp, bus_rdata);
    endtask

    task automatic do_reset();
        @(posedge ref_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        #1;
    endtask

    initial begin
        do_reset();
        rd_chk("tbl_rst", OFF_TABLE_OFFSET, 32'h00000000);
        rd_chk("app_rst", OFF_APP_RESET, 32'hfa050000);
        rd_chk("ctl_rst", OFF_CTRL_STATE, 32'h00000800);
        @(posedge ref_clk);
        #1;
        chk("rdata_idle", 32'h0, bus_rdata);
        rd_chk("unmapped", 8'h0c, 32'h0);
        $display("test reset_values done");

        bus_write(OFF_TABLE_OFFSET, 32'hffffff00);
        chk("tbl_sram", 32'h1, {31'h0, table_in_sram});
        rd_chk("tbl_all", OFF_TABLE_OFFSET, 32'hffffff00);
        bus_write(OFF_TABLE_OFFSET, 32'h1fffff00);
        chk("tbl_code", 32'h0, {31'h0, table_in_sram});
        chk("tbl_addr", 32'h1fffff00, table_base_addr);
        bus_write(8'h0c, 32'h12345680);
        rd_chk("tbl_keep", OFF_TABLE_OFFSET, 32'h1fffff00);
        $display("test table_offset done");

        for (int n = 0; n < 8; n++) begin
            bus_write(OFF_APP_RESET, {16'h05fa, 5'h0, n[2:0], 8'h00});
            chk("split_out", {29'h0, n[2:0]}, {29'h0, priority_split});
            rd_chk("split_rd", OFF_APP_RESET, {16'hfa05, 5'h0, n[2:0], 8'h00});
        end
        // A wrong key must leave the grouping and the reset request untouched.
        bus_write(OFF_APP_RESET, 32'h05fb7bfc);
        rd_chk("bad_key", OFF_APP_RESET, 32'hfa050700);
        chk("bad_key_req", 32'h0, {31'h0, system_reset_request});
        $display("test app_reset done");

        @(posedge ref_clk);
        exc_pending[3] <= 1'b1;
        exc_enabled[3] <= 1'b1;
        exc_prio[3*8+:8] <= 8'h10;
        exc_active[20] <= 1'b1;
        active_exception_number <= 9'd20;
        running_prio <= 8'h11;
        rd_chk("ctl_act", OFF_CTRL_STATE, 32'h00003814);
        chk("pre_split7", 32'h0, {31'h0, preempt_allowed});
        bus_write(OFF_APP_RESET, 32'h05fa0000);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("pre_subprio", 32'h0, {31'h0, preempt_allowed});
        @(posedge ref_clk);
        running_prio <= 8'h12;
        repeat (2) @(posedge ref_clk);
        #1;
        chk("pre_group", 32'h1, {31'h0, preempt_allowed});
        @(posedge ref_clk);
        exc_active[30] <= 1'b1;
        exc_prio[30*8+:8] <= 8'h40;
        debug_state_bit <= 1'b1;
        rd_chk("ctl_nest", OFF_CTRL_STATE, 32'h00003014);
        @(posedge ref_clk);
        debug_halted <= 1'b1;
        rd_chk("ctl_dbg", OFF_CTRL_STATE, 32'h00803014);
        @(posedge ref_clk);
        debug_halted <= 1'b0;
        exc_active <= '0;
        active_exception_number <= 9'd0;
        // Exceptions 20, 30 and 40 pending; 3, 20 and 30 enabled.
        exc_pending <= 48'h010040100000;
        exc_enabled <= 48'h000040100008;
        exc_prio[20*8+:8] <= 8'h20;
        rd_chk("pend_win", OFF_CTRL_STATE, 32'h00414800);
        chk("pre_thread", 32'h1, {31'h0, preempt_allowed});
        @(posedge ref_clk);
        base_priority_mask <= 8'h30;
        rd_chk("pend_base_lo", OFF_CTRL_STATE, 32'h00414800);
        @(posedge ref_clk);
        base_priority_mask <= 8'h20;
        rd_chk("pend_base_eq", OFF_CTRL_STATE, 32'h00400800);
        @(posedge ref_clk);
        base_priority_mask <= 8'h00;
        fault_mask_a <= 1'b1;
        rd_chk("pend_fault", OFF_CTRL_STATE, 32'h00400800);
        @(posedge ref_clk);
        exc_pending[2] <= 1'b1;
        exc_enabled[2] <= 1'b1;
        rd_chk("pend_nmi", OFF_CTRL_STATE, 32'h00402800);
        $display("test status done");

        bus_write(OFF_CTRL_STATE, 32'h02000000);
        chk("tick_pulse", 32'h1, {31'h0, tick_pend_clear});
        @(posedge ref_clk);
        #1;
        chk("tick_end", 32'h0, {31'h0, tick_pend_clear});
        bus_write(OFF_CTRL_STATE, 32'h00000000);
        chk("tick_zero", 32'h0, {31'h0, tick_pend_clear});
        $display("test tick_clear done");

        bus_write(OFF_APP_RESET, 32'h05fa0504);
        chk("req_set", 32'h1, {31'h0, system_reset_request});
        rd_chk("req_rd", OFF_APP_RESET, 32'hfa050500);
        bus_write(OFF_APP_RESET, 32'h05fa0200);
        chk("req_hold", 32'h1, {31'h0, system_reset_request});
        do_reset();
        chk("req_clear", 32'h0, {31'h0, system_reset_request});
        rd_chk("app_rerst", OFF_APP_RESET, 32'hfa050000);
        $display("test system_reset done");
        wrap_up();
    end
endmodule // testbench
